// ==== verilog/p3cio_port.sv ====
/*
 Port three block: three fixed inputs, three push-pull outputs (line four undriven in reset, on serial clock enable under serial control), two comparators,
 edge interrupt sources, comparator routing, low-emission drive control and
 register pointer bank select.
 Assumes the core drives an 8-bit register access port synchronous to clk_in,
 and that comparator results arrive as synchronous digital levels.
*/
`timescale 1ns/10ps

// Operation
// - Six lines: lines one to three fixed inputs, four to six fixed outputs.
// - Inputs are plain, unlatched; outputs drive both levels, except line four during reset or under serial control.
// - Config bits 4 and 3 put port three and port two outputs into low-emission drive.
// - Mode bit D1 enables analog mode with two comparators.
// - Analog: lines one and two positive inputs, line three common reference.
// - Lines one and two interrupt on fall, rise or both per bits 6 and 7.
// - Line three gives falling-edge interrupts only, and only in digital mode.
// - Digital mode: line three readable in port data, feeds interrupt one.
// - Lines one and two interrupt in both modes; line one is timer input.
// - Config bit D0 routes comparator results to lines four and five.
// - Timer one input on line one, output on line six.
// - With serial enabled, line four serial clock, line two slave select.
// - Oscillator and each port group get independent low-emission bits.
// - Reset on power-on, watchdog, stop recovery or low voltage.
// - Reset lasts 5 ms plus 18 clocks, no external circuit.
// - Stop recovery reset keeps the port three mode register.
// - Pointer bits 3-0 select bank, 7-4 working group; bank F holds config.
module p3cio_port #(
    parameter int POWERUP_CYCLES = p3cio_pkg::POWERUP_CYCLES
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic watchdog_rst_in,
    input wire logic stop_recovery_rst_in,
    input wire logic low_voltage_rst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic input_line_one_in,
    input wire logic input_line_two_in,
    input wire logic input_line_three_in,
    input wire logic cmp_one_result_in,
    input wire logic cmp_two_result_in,
    input wire logic timer_out_in,
    input wire logic serial_en_in,
    input wire logic serial_clock_pin_o_in,
    input wire logic serial_clock_pin_oe_in,
    output logic [7:0] reg_rdata_out,
    output logic output_line_four_out,
    output logic output_line_four_oe_out,
    output logic output_line_five_out,
    output logic output_line_six_out,
    output logic serial_clock_pin_out,
    output logic slave_select_out,
    output logic timer_ext_in_out,
    output logic edge_interrupt_zero_out,
    output logic edge_interrupt_one_out,
    output logic edge_interrupt_two_out,
    output logic analog_mode_out,
    output logic port3_low_emi_out,
    output logic osc_low_emi_out,
    output logic port2_low_emi_out,
    output logic sys_reset_out
);

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    p3cio_pkg::p3cio_rst_state_t rst_state_reg, rst_state_next;
    logic [p3cio_pkg::RESET_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
    logic stop_pending_reg;
    wire any_soft_rst = watchdog_rst_in | stop_recovery_rst_in | low_voltage_rst_in;
    wire [p3cio_pkg::RESET_CNT_W-1:0] power_last = p3cio_pkg::RESET_CNT_W'(POWERUP_CYCLES - 1);
    wire [p3cio_pkg::RESET_CNT_W-1:0] tail_last = p3cio_pkg::RESET_CNT_W'(p3cio_pkg::RESET_TAIL_CYCLES - 1);
    wire cnt_done_power = (rst_cnt_reg == power_last);
    wire cnt_done_tail = (rst_cnt_reg == tail_last);
    wire in_reset = (rst_state_reg != p3cio_pkg::P3CIO_RST_RUN);
    // Last tail cycle of a stop recovery restart; the mode register is kept throughout
    wire stop_release = stop_pending_reg & (rst_state_reg == p3cio_pkg::P3CIO_RST_TAIL) & cnt_done_tail;

    always_comb begin
        rst_state_next = rst_state_reg;
        rst_cnt_next = rst_cnt_reg + 1'b1;
        unique case (rst_state_reg)
            p3cio_pkg::P3CIO_RST_POWER: begin
                if (cnt_done_power) begin
                    rst_state_next = p3cio_pkg::P3CIO_RST_TAIL;
                    rst_cnt_next = '0;
                end
            end
            p3cio_pkg::P3CIO_RST_TAIL: begin
                if (cnt_done_tail) begin
                    rst_state_next = p3cio_pkg::P3CIO_RST_RUN;
                    rst_cnt_next = '0;
                end
            end
            p3cio_pkg::P3CIO_RST_RUN: begin
                rst_cnt_next = '0;
            end
            default: begin
                rst_state_next = p3cio_pkg::P3CIO_RST_POWER;
                rst_cnt_next = '0;
            end
        endcase
        if (any_soft_rst) begin
            rst_state_next = p3cio_pkg::P3CIO_RST_POWER;
            rst_cnt_next = '0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_state_reg <= p3cio_pkg::P3CIO_RST_POWER;
            rst_cnt_reg <= '0;
            stop_pending_reg <= 1'b0;
        end else begin
            rst_state_reg <= rst_state_next;
            rst_cnt_reg <= rst_cnt_next;
            if (watchdog_rst_in | low_voltage_rst_in) begin
                stop_pending_reg <= 1'b0;
            end else if (stop_recovery_rst_in) begin
                stop_pending_reg <= 1'b1;
            end else if (!in_reset) begin
                stop_pending_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    logic [7:0] reg_pointer_reg, port3_data_reg, port_config_reg, port_three_mode_reg, int_request_reg;
    wire [3:0] exp_bank = reg_pointer_reg[3:0];
    wire in_bank_port = (exp_bank == p3cio_pkg::BANK_PORT);
    wire in_bank_cfg = (exp_bank == p3cio_pkg::BANK_CONFIG);
    wire sel_data = in_bank_port & (reg_addr_in == p3cio_pkg::ADDR_PORT3_DATA);
    wire sel_cfg = in_bank_cfg & (reg_addr_in == p3cio_pkg::ADDR_PORT_CONFIG);
    wire sel_mode = (reg_addr_in == p3cio_pkg::ADDR_PORT3_MODE);
    wire sel_irq = (reg_addr_in == p3cio_pkg::ADDR_INT_REQUEST);
    wire sel_rp = (reg_addr_in == p3cio_pkg::ADDR_REG_POINTER);
    wire wr_ok = reg_wr_in & ~in_reset;
    wire analog_mode = port_three_mode_reg[p3cio_pkg::MODE_ANALOG_BIT];
    wire cmp_route = port_config_reg[p3cio_pkg::CFG_CMP_ROUTE_BIT];
    wire [1:0] edge_sel = int_request_reg[p3cio_pkg::IRQ_EDGE_HI_BIT:p3cio_pkg::IRQ_EDGE_LO_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Edge sources

    logic irq_one_pulse, irq_two_pulse, irq_three_pulse;
    wire fall_en = (edge_sel != 2'h1);
    wire rise_en = (edge_sel != 2'h0);

    // Lines one and two stay interrupt sources in either mode
    p3cio_edge_detect u_edge_one (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .run_in(~in_reset),
        .level_in(input_line_one_in),
        .rise_en_in(rise_en),
        .fall_en_in(fall_en),
        .pulse_out(irq_one_pulse)
    );
    p3cio_edge_detect u_edge_two (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .run_in(~in_reset),
        .level_in(input_line_two_in),
        .rise_en_in(rise_en),
        .fall_en_in(fall_en),
        .pulse_out(irq_two_pulse)
    );
    p3cio_edge_detect u_edge_three (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .run_in(~in_reset & ~analog_mode),
        .level_in(input_line_three_in),
        .rise_en_in(1'b0),
        .fall_en_in(1'b1),
        .pulse_out(irq_three_pulse)
    );

    // Hardware set wins over a same-cycle software write
    wire [7:0] irq_set = {5'h00, irq_one_pulse, irq_three_pulse, irq_two_pulse};
    wire [7:0] irq_base = (wr_ok & sel_irq) ? reg_wdata_in : int_request_reg;
    wire [7:0] int_request_next = irq_base | irq_set;

    // Mode register survives a stop recovery restart
    wire [7:0] port_three_mode_next = (wr_ok & sel_mode) ? reg_wdata_in : port_three_mode_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_pointer_reg <= p3cio_pkg::RST_REG_POINTER;
            port3_data_reg <= p3cio_pkg::RST_PORT3_DATA;
            port_config_reg <= p3cio_pkg::RST_PORT_CONFIG;
            port_three_mode_reg <= p3cio_pkg::RST_PORT3_MODE;
            int_request_reg <= p3cio_pkg::RST_INT_REQUEST;
        end else if (in_reset) begin
            reg_pointer_reg <= p3cio_pkg::RST_REG_POINTER;
            port3_data_reg <= p3cio_pkg::RST_PORT3_DATA;
            port_config_reg <= p3cio_pkg::RST_PORT_CONFIG;
            int_request_reg <= p3cio_pkg::RST_INT_REQUEST;
            if (!(stop_pending_reg | stop_recovery_rst_in)) begin
                port_three_mode_reg <= p3cio_pkg::RST_PORT3_MODE;
            end
        end else begin
            if (wr_ok & sel_rp) begin
                reg_pointer_reg <= reg_wdata_in;
            end
            if (wr_ok & sel_data) begin
                port3_data_reg <= reg_wdata_in;
            end
            if (wr_ok & sel_cfg) begin
                port_config_reg <= reg_wdata_in;
            end
            port_three_mode_reg <= port_three_mode_next;
            int_request_reg <= int_request_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and pins

    // Line three reads as zero in analog mode; it is the reference there
    wire line3_read = input_line_three_in & ~analog_mode;
    wire [7:0] data_read = {port3_data_reg[7:4], line3_read, input_line_two_in, input_line_one_in, 1'b0};
    wire [7:0] rdata_mux = sel_data ? data_read :
                           sel_cfg ? port_config_reg :
                           sel_mode ? port_three_mode_reg :
                           sel_irq ? int_request_reg :
                           sel_rp ? reg_pointer_reg : 8'h00;

    wire four_port = cmp_route ? cmp_one_result_in : port3_data_reg[4];
    wire five_port = cmp_route ? cmp_two_result_in : port3_data_reg[5];
    wire four_val = serial_en_in ? serial_clock_pin_o_in : four_port;
    wire four_oe = serial_en_in ? serial_clock_pin_oe_in : 1'b1;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 8'h00;
            output_line_four_out <= 1'b0;
            output_line_four_oe_out <= 1'b0;
            output_line_five_out <= 1'b0;
            output_line_six_out <= 1'b0;
            serial_clock_pin_out <= 1'b0;
            slave_select_out <= 1'b1;
            timer_ext_in_out <= 1'b0;
            edge_interrupt_zero_out <= 1'b0;
            edge_interrupt_one_out <= 1'b0;
            edge_interrupt_two_out <= 1'b0;
            analog_mode_out <= 1'b0;
            port3_low_emi_out <= 1'b0;
            osc_low_emi_out <= 1'b0;
            port2_low_emi_out <= 1'b0;
            sys_reset_out <= 1'b1;
        end else begin
            reg_rdata_out <= reg_rd_in ? rdata_mux : 8'h00;
            output_line_four_out <= four_val;
            output_line_four_oe_out <= four_oe & ~in_reset;
            output_line_five_out <= five_port;
            output_line_six_out <= timer_out_in;
            serial_clock_pin_out <= input_line_one_in ? 1'b0 : 1'b0;
            slave_select_out <= serial_en_in ? input_line_two_in : 1'b1;
            timer_ext_in_out <= input_line_one_in;
            edge_interrupt_zero_out <= int_request_reg[p3cio_pkg::IRQ_LINE_TWO_BIT];
            edge_interrupt_one_out <= int_request_reg[p3cio_pkg::IRQ_LINE_THREE_BIT];
            edge_interrupt_two_out <= int_request_reg[p3cio_pkg::IRQ_LINE_ONE_BIT];
            analog_mode_out <= analog_mode;
            port3_low_emi_out <= ~port_config_reg[p3cio_pkg::CFG_EMI_PORT3_BIT];
            osc_low_emi_out <= ~port_config_reg[p3cio_pkg::CFG_EMI_OSC_BIT];
            port2_low_emi_out <= ~port_config_reg[p3cio_pkg::CFG_EMI_PORT3_BIT - 1];
            sys_reset_out <= in_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_line3_analog_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        analog_mode |-> !irq_three_pulse) else $error("line three interrupt in analog mode");
    a_line3_fall_only: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        irq_three_pulse |-> !input_line_three_in && $past(input_line_three_in)) else $error("line three bad edge");
    a_route_four: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (cmp_route && !serial_en_in) |=> output_line_four_out == $past(cmp_one_result_in)) else $error("route four");
    a_route_five: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cmp_route |=> output_line_five_out == $past(cmp_two_result_in)) else $error("route five");
    a_data_five: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !cmp_route |=> output_line_five_out == $past(port3_data_reg[5])) else $error("data five");
    a_timer_six: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> output_line_six_out == $past(timer_out_in)) else $error("timer out");
    a_rise_only: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (edge_sel == 2'h1 && irq_one_pulse) |-> input_line_one_in) else $error("rise select");
    a_irq_sticky: assert property (@(posedge clk_in) disable iff (!arst_n_in || in_reset)
        irq_one_pulse |=> int_request_reg[p3cio_pkg::IRQ_LINE_ONE_BIT]) else $error("irq lost");
    a_tail_len: assert property (@(posedge clk_in) disable iff (!arst_n_in || any_soft_rst)
        $rose(rst_state_reg == p3cio_pkg::P3CIO_RST_TAIL) |-> ##18 !in_reset) else $error("tail length");
    a_mode_kept: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (stop_recovery_rst_in && !watchdog_rst_in && !low_voltage_rst_in && !in_reset)
        |=> port_three_mode_reg == $past(port_three_mode_reg)) else $error("mode lost");
    a_push_pull: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!serial_en_in && !in_reset) |=> output_line_four_oe_out) else $error("four not driven");

    c_analog_on: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(analog_mode));
    c_route_on: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(cmp_route));
    c_both_edges: cover property (@(posedge clk_in) disable iff (!arst_n_in) edge_sel == 2'h3 && irq_two_pulse);
    c_stop_release: cover property (@(posedge clk_in) disable iff (!arst_n_in) stop_release);
endmodule

// ==== verilog/p3cio_pkg.sv ====
/*
 Constants for the six-line comparator I/O port block.
 Assumes an 8-bit register access port of the surrounding core.
*/
package p3cio_pkg;
    // Register file addresses
    localparam logic [7:0] ADDR_PORT3_DATA = 8'h03;
    localparam logic [7:0] ADDR_PORT_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PORT3_MODE = 8'hF7;
    localparam logic [7:0] ADDR_INT_REQUEST = 8'hFA;
    localparam logic [7:0] ADDR_REG_POINTER = 8'hFD;
    localparam logic [3:0] BANK_CONFIG = 4'hF;
    localparam logic [3:0] BANK_PORT = 4'h0;
    // Field positions
    localparam int MODE_ANALOG_BIT = 1;
    localparam int CFG_CMP_ROUTE_BIT = 0;
    localparam int CFG_EMI_PORT3_BIT = 4;
    localparam int CFG_EMI_OSC_BIT = 7;
    localparam int IRQ_EDGE_LO_BIT = 6;
    localparam int IRQ_EDGE_HI_BIT = 7;
    localparam int IRQ_LINE_TWO_BIT = 0;
    localparam int IRQ_LINE_THREE_BIT = 1;
    localparam int IRQ_LINE_ONE_BIT = 2;
    // Values after reset
    localparam logic [7:0] RST_PORT3_DATA = 8'h00;
    localparam logic [7:0] RST_PORT_CONFIG = 8'h7E;
    localparam logic [7:0] RST_PORT3_MODE = 8'h00;
    localparam logic [7:0] RST_INT_REQUEST = 8'h00;
    localparam logic [7:0] RST_REG_POINTER = 8'h00;
    // Reset stretch: power-up delay plus clock cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_DELAY_MS = 5;
    localparam int POWERUP_CYCLES = POWERUP_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RESET_TAIL_CYCLES = 18;
    localparam int RESET_CNT_W = 20;
    typedef enum logic [2:0] {
        P3CIO_RST_POWER = 3'h1,
        P3CIO_RST_TAIL = 3'h2,
        P3CIO_RST_RUN = 3'h4
    } p3cio_rst_state_t;
endpackage

// ==== verilog/p3cio_edge_detect.sv ====
/*
 Edge detector for one port input line with selectable edges.
 Assumes input already synchronous to clk_in.
*/
`timescale 1ns/10ps
module p3cio_edge_detect (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic run_in,
    input wire logic level_in,
    input wire logic rise_en_in,
    input wire logic fall_en_in,
    output logic pulse_out
);
    logic prev_reg;
    wire rise_seen = level_in & ~prev_reg;
    wire fall_seen = ~level_in & prev_reg;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level_in;
        end
    end
    assign pulse_out = run_in & ((rise_seen & rise_en_in) | (fall_seen & fall_en_in));
endmodule

// ==== dv/p3cio_pin_model.sv ====
/*
 Far-side model of the port three pins: three input levels and two comparator results.
 Assumes the bench sets pin voltages through set_levels; outputs change on the rising clock edge.
*/
`timescale 1ns/10ps
module p3cio_pin_model (
    input wire logic clk_in,
    output logic line_one_out = 1'b0,
    output logic line_two_out = 1'b0,
    output logic line_three_out = 1'b0,
    output logic cmp_one_out = 1'b0,
    output logic cmp_two_out = 1'b0
);
    ////////////////////////////////////////////////////////////////////////////////
    localparam real V_SWITCH = 2.5;
    real v_one = 0.0;
    real v_two = 0.0;
    real v_ref = 0.0;

    task automatic set_levels(input real a, input real b, input real r);
        v_one = a;
        v_two = b;
        v_ref = r;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Levels held as synchronous steps, since the block expects synchronised inputs
    always @(posedge clk_in) begin
        line_one_out <= (v_one > V_SWITCH);
        line_two_out <= (v_two > V_SWITCH);
        line_three_out <= (v_ref > V_SWITCH);
        cmp_one_out <= (v_one > v_ref);
        cmp_two_out <= (v_two > v_ref);
    end
endmodule

// ==== dv/p3cio_port_bench.sv ====
/*
 Self-checking bench for the port three block with a pin model on the far side.
 Assumes the reset stretch parameter is shortened to 20 cycles for simulation.
*/
`timescale 1ns/10ps
module p3cio_port_bench;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [2:0] soft_rst = 3'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic timer_out = 1'b0;
    logic serial_en = 1'b0;
    logic sk_o = 1'b0;
    logic sk_oe = 1'b0;
    wire logic six, sk_pin, ssel, osc_emi;
    wire logic line_one, line_two, line_three, cmp_one, cmp_two;
    wire logic four, four_oe, five, t_ext, irq0, edge_interrupt_one, irq2, analog, p3_emi, p2_emi, sys_rst;
    wire logic [7:0] rdata;
    int err_count = 0;
    int num_checks = 0;

    always #5 clk_in = ~clk_in;

    p3cio_pin_model u_p3cio_pin_model (.clk_in(clk_in), .line_one_out(line_one), .line_two_out(line_two),
        .line_three_out(line_three), .cmp_one_out(cmp_one), .cmp_two_out(cmp_two));

    p3cio_port #(.POWERUP_CYCLES(20)) u_p3cio_port (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .watchdog_rst_in(soft_rst[0]), .stop_recovery_rst_in(soft_rst[1]), .low_voltage_rst_in(soft_rst[2]),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .input_line_one_in(line_one), .input_line_two_in(line_two), .input_line_three_in(line_three),
        .cmp_one_result_in(cmp_one), .cmp_two_result_in(cmp_two), .timer_out_in(timer_out),
        .serial_en_in(serial_en), .serial_clock_pin_o_in(sk_o), .serial_clock_pin_oe_in(sk_oe),
        .reg_rdata_out(rdata), .output_line_four_out(four), .output_line_four_oe_out(four_oe),
        .output_line_five_out(five), .output_line_six_out(six), .serial_clock_pin_out(sk_pin),
        .slave_select_out(ssel), .timer_ext_in_out(t_ext),
        .edge_interrupt_zero_out(irq0), .edge_interrupt_one_out(edge_interrupt_one), .edge_interrupt_two_out(irq2),
        .analog_mode_out(analog), .port3_low_emi_out(p3_emi), .osc_low_emi_out(osc_emi),
        .port2_low_emi_out(p2_emi), .sys_reset_out(sys_rst));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait for the reset stretch to end
    task automatic wait_run(output int n);
        n = 0;
        while (sys_rst !== 1'b0 && n < 200) begin
            idle(1);
            n++;
        end
        if (sys_rst !== 1'b0) begin
            err_count++;
            $display("wrong value reset end expected 0 seen %b", sys_rst);
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic scen_regs();
        logic [7:0] d;
        rd(8'hFD, d);
        chk("pointer after reset", 8'h00, d);
        rd(8'h00, d);
        chk("config hidden in bank zero", 8'h00, d);
        wr(8'hFD, 8'h0F);
        rd(8'h00, d);
        chk("config in bank F", 8'h7E, d);
        rd(8'h03, d);
        chk("data hidden in bank F", 8'h00, d);
    endtask

    task automatic scen_outputs();
        wr(8'hFD, 8'h00);
        wr(8'h03, 8'h10);
        idle(3);
        chk("lines from data", 8'h05, {5'h00, four_oe, five, four});
        wr(8'h03, 8'h00);
        wr(8'hFD, 8'h0F);
        wr(8'h00, 8'h7F);
        u_p3cio_pin_model.set_levels(3.0, 1.0, 2.0);
        idle(4);
        chk("routed results one", 8'h05, {5'h00, four_oe, five, four});
        u_p3cio_pin_model.set_levels(1.0, 3.0, 2.0);
        idle(4);
        chk("routed results two", 8'h06, {5'h00, four_oe, five, four});
        wr(8'h00, 8'h7E);
    endtask

    task automatic scen_edges();
        logic [1:0] code;
        for (int m = 0; m < 4; m++) begin
            code = m[1:0];
            u_p3cio_pin_model.set_levels(0.0, 0.0, 1.0);
            idle(3);
            wr(8'hFA, {code, 6'h00});
            u_p3cio_pin_model.set_levels(4.0, 4.0, 1.0);
            idle(4);
            chk("rise requests", {6'h00, code != 2'b00, code != 2'b00}, {6'h00, irq2, irq0});
            wr(8'hFA, {code, 6'h00});
            u_p3cio_pin_model.set_levels(0.0, 0.0, 1.0);
            idle(4);
            chk("fall requests", {6'h00, code != 2'b01, code != 2'b01}, {6'h00, irq2, irq0});
        end
    endtask

    task automatic scen_analog();
        logic [7:0] d;
        for (int a = 0; a < 2; a++) begin
            wr(8'hF7, {6'h00, a[0], 1'b0});
            u_p3cio_pin_model.set_levels(0.0, 0.0, 4.0);
            idle(3);
            wr(8'hFA, 8'h80);
            u_p3cio_pin_model.set_levels(4.0, 0.0, 0.0);
            idle(4);
            chk("analog flag", {7'h00, a[0]}, {7'h00, analog});
            chk("line three request", {7'h00, ~a[0]}, {7'h00, edge_interrupt_one});
            chk("line one request", 8'h01, {7'h00, irq2});
            chk("timer input copy", 8'h01, {7'h00, t_ext});
            u_p3cio_pin_model.set_levels(4.0, 0.0, 4.0);
            wr(8'hFD, 8'h00);
            idle(3);
            rd(8'h03, d);
            chk("input lines read", {4'h0, ~a[0], 3'b010}, d & 8'h0E);
        end
        wr(8'hF7, 8'h00);
    endtask

    task automatic scen_emi();
        wr(8'hFD, 8'h0F);
        wr(8'h00, 8'h6E);
        idle(3);
        chk("port three low emission", 8'h02, {6'h00, p3_emi, p2_emi});
        chk("oscillator low emission", 8'h01, {7'h00, osc_emi});
        wr(8'h00, 8'h76);
        idle(3);
        chk("port two low emission", 8'h01, {6'h00, p3_emi, p2_emi});
        wr(8'h00, 8'hFE);
        idle(3);
        chk("oscillator normal drive", 8'h00, {7'h00, osc_emi});
        wr(8'h00, 8'h7E);
    endtask

    task automatic scen_serial_timer();
        @(posedge clk_in);
        timer_out <= 1'b1;
        idle(2);
        chk("timer output", 8'h01, {7'h00, six});
        u_p3cio_pin_model.set_levels(0.0, 0.0, 1.0);
        @(posedge clk_in);
        timer_out <= 1'b0;
        serial_en <= 1'b1;
        sk_o <= 1'b1;
        idle(3);
        chk("timer output low", 8'h00, {7'h00, six});
        chk("serial on line four", 8'h01, {4'h0, ssel, sk_pin, four_oe, four});
        u_p3cio_pin_model.set_levels(0.0, 4.0, 1.0);
        @(posedge clk_in);
        sk_oe <= 1'b1;
        idle(3);
        chk("slave select follows", 8'h0B, {4'h0, ssel, sk_pin, four_oe, four});
        @(posedge clk_in);
        serial_en <= 1'b0;
        sk_o <= 1'b0;
        sk_oe <= 1'b0;
        idle(2);
        chk("serial released", 8'h0A, {4'h0, ssel, sk_pin, four_oe, four});
    endtask

    // Stop recovery must keep the mode register, other causes restore it
    task automatic scen_soft_reset();
        logic [7:0] d;
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(8'hF7, 8'h02);
            @(posedge clk_in);
            soft_rst[i] <= 1'b1;
            @(posedge clk_in);
            soft_rst[i] <= 1'b0;
            idle(1);
            chk("soft reset entered", 8'h01, {7'h00, sys_rst});
            wait_run(n);
            rd(8'hF7, d);
            chk("mode after soft reset", (i == 1) ? 8'h02 : 8'h00, d);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #900000;
        err_count++;
        $display("wrong value run time expected done seen hang");
        end_sim();
    end

    initial begin
        int n;
        repeat (6) @(posedge clk_in);
        chk("reset flag held", 8'h01, {7'h00, sys_rst});
        arst_n_in <= 1'b1;
        wait_run(n);
        chk("reset length in range", 8'h01, {7'h00, n >= 38 && n <= 41});
        scen_regs();
        scen_outputs();
        scen_edges();
        scen_analog();
        scen_emi();
        scen_serial_timer();
        scen_soft_reset();
        end_sim();
    end
endmodule
